//--- src/lmscp_device.sv
/*
 * device end of the led matrix serial command port: mode decoding,
 * display ram access with address auto-increment, command decoding.
 * assumes the link clock is much faster than the strobes; all pins
 * pass two flip-flops; the ram read port is on the link clock.
 */
// What this block does
// - 110 plus address returns addressed nibble
// - 101 plus address and nibble stores it
// - 101 read strobes then write strobes: rmw
// - address msb first, data lsb first
// - further write nibbles go to next address
// - rmw pairs advance address by one
// - 100 then nine-bit command, msb first
// - further commands need no repeated mode
// - oscillator off also stops duty generator
// - oscillator enable starts oscillator
// - display off; default after reset
// - display on enables duty generator
// - blink off default, blink on enables
// - slave mode uses outside clock source
// - leader mode uses internal oscillator
// - host sets one leader, separate selects
// - bits sampled on write strobe rise
// - read bits driven on read strobe fall
// - raised select resets mode, needs new id
`timescale 1ns/1ns
module lmscp_device (
  input wire logic link_clk_in,
  input wire logic rst_b_in,
  lmscp_link_if.dev link,
  input wire logic [6:0] ram_rd_addr_in,
  output logic [3:0] ram_rd_data_out,
  output logic osc_en_out,
  output logic display_en_out,
  output logic blink_en_out,
  output logic leader_mode_out,
  output logic [3:0] pwm_duty_out
);

  typedef enum logic [2:0] {
    D_MODE = 3'b000,
    D_ADDR = 3'b001,
    D_DATA = 3'b010,
    D_CMD = 3'b011,
    D_IGNORE = 3'b100
  } lmscp_dst_t;

  // ****************************************
  // command decoder
  // ****************************************
  function automatic lmscp_pkg::lmscp_cfg_t cmd_decode(input logic [8:0] c,
                                                        input lmscp_pkg::lmscp_cfg_t cur);
    lmscp_pkg::lmscp_cfg_t n;
    n = cur;
    if (c[lmscp_pkg::C_HI:lmscp_pkg::C_GRP_LO] == lmscp_pkg::GRP_SYS) begin
      case (c[lmscp_pkg::C_OP_HI:lmscp_pkg::C_OP_LO])
        lmscp_pkg::OP_OSC_OFF: begin
          n.osc_en = 1'b0;
          n.disp_en = 1'b0;
        end
        lmscp_pkg::OP_OSC_ON: n.osc_en = 1'b1;
        lmscp_pkg::OP_DISP_OFF: n.disp_en = 1'b0;
        lmscp_pkg::OP_DISP_ON: n.disp_en = 1'b1;
        lmscp_pkg::OP_BLINK_OFF: n.blink_en = 1'b0;
        lmscp_pkg::OP_BLINK_ON: n.blink_en = 1'b1;
        default: n = cur;
      endcase
    end else if (c[lmscp_pkg::C_HI:lmscp_pkg::C_SLV_LO] == lmscp_pkg::PFX_SLAVE) begin
      n.leader = 1'b0;
    end else if (c[lmscp_pkg::C_HI:lmscp_pkg::C_LDR_LO] == lmscp_pkg::PFX_LEADER) begin
      n.leader = 1'b1;
    end else if (c[lmscp_pkg::C_HI:lmscp_pkg::C_PWM_LO] == lmscp_pkg::PFX_PWM) begin
      n.pwm = c[lmscp_pkg::C_OP_HI:lmscp_pkg::C_OP_LO];
    end
    return n;
  endfunction

  logic [3:0] sync1_r, sync2_r, prev_r;
  logic [3:0] sync1_nxt, sync2_nxt, prev_nxt;
  lmscp_dst_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] rcnt_r, rcnt_nxt;
  logic [8:0] shift_r, shift_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic rd_mode_r, rd_mode_nxt;
  logic dout_r, dout_nxt;
  logic doe_b_r, doe_b_nxt;
  lmscp_pkg::lmscp_cfg_t cfg_r, cfg_nxt;
  logic [3:0] ram_r [0:lmscp_pkg::RAM_DEPTH-1];
  logic [3:0] ram_nxt [0:lmscp_pkg::RAM_DEPTH-1];
  logic [3:0] rdat_r, rdat_nxt;
  logic wr_rise, wr_fall, rd_fall, bit_in;
  logic [8:0] word;
  logic [3:0] nib;
  logic [2:0] mode_id;

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  // first stage feeds only the second stage
  always_comb begin
    sync1_nxt = {link.cs_b, link.wr_b, link.rd_b, link.data_line};
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_r <= lmscp_pkg::PIN_IDLE;
      sync2_r <= lmscp_pkg::PIN_IDLE;
      prev_r <= lmscp_pkg::PIN_IDLE;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign wr_rise = sync2_r[lmscp_pkg::PIN_WR] & ~prev_r[lmscp_pkg::PIN_WR];
  assign wr_fall = ~sync2_r[lmscp_pkg::PIN_WR] & prev_r[lmscp_pkg::PIN_WR];
  assign rd_fall = ~sync2_r[lmscp_pkg::PIN_RD] & prev_r[lmscp_pkg::PIN_RD];
  assign bit_in = sync2_r[lmscp_pkg::PIN_DAT];
  assign word = {shift_r[lmscp_pkg::CMD_W-2:0], bit_in}; // msb-first accumulation
  assign nib = {bit_in, shift_r[lmscp_pkg::NIB_W-1:1]}; // lsb-first accumulation
  assign mode_id = word[lmscp_pkg::LAST_MODE:0]; // three id bits just collected

  // ****************************************
  // protocol, ram and configuration
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rcnt_nxt = rcnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    rd_mode_nxt = rd_mode_r;
    dout_nxt = dout_r;
    doe_b_nxt = doe_b_r;
    cfg_nxt = cfg_r;
    ram_nxt = ram_r;
    rdat_nxt = ram_r[ram_rd_addr_in];
    if (sync2_r[lmscp_pkg::PIN_CS]) begin
      state_nxt = D_MODE;
      cnt_nxt = 4'h0;
      rcnt_nxt = 2'h0;
      doe_b_nxt = 1'b1;
    end else begin
      // host takes the line back when it lowers the write strobe
      if (wr_fall) begin
        doe_b_nxt = 1'b1;
      end
      if (wr_rise) begin
        shift_nxt = word;
        cnt_nxt = cnt_r + 4'h1;
        unique case (state_r)
          D_MODE: begin
            if (cnt_r == lmscp_pkg::LAST_MODE) begin
              cnt_nxt = 4'h0;
              rd_mode_nxt = (mode_id == lmscp_pkg::MODE_READ);
              if (mode_id == lmscp_pkg::MODE_READ || mode_id == lmscp_pkg::MODE_WRITE) begin
                state_nxt = D_ADDR;
              end else if (mode_id == lmscp_pkg::MODE_CMD) begin
                state_nxt = D_CMD;
              end else begin
                state_nxt = D_IGNORE;
              end
            end
          end
          D_ADDR: begin
            if (cnt_r == lmscp_pkg::LAST_ADDR) begin
              addr_nxt = word[lmscp_pkg::ADDR_W-1:0];
              cnt_nxt = 4'h0;
              rcnt_nxt = 2'h0;
              state_nxt = D_DATA;
            end
          end
          D_DATA: begin
            shift_nxt = {shift_r[lmscp_pkg::CMD_W-1:lmscp_pkg::NIB_W], nib};
            if (rd_mode_r) begin
              cnt_nxt = cnt_r;
            end else if (cnt_r == lmscp_pkg::LAST_NIB) begin
              ram_nxt[addr_r] = nib;
              addr_nxt = addr_r + 7'h01;
              cnt_nxt = 4'h0;
              rcnt_nxt = 2'h0;
            end
          end
          D_CMD: begin
            if (cnt_r == lmscp_pkg::LAST_CMD) begin
              cfg_nxt = cmd_decode(word, cfg_r);
              cnt_nxt = 4'h0;
            end
          end
          D_IGNORE: cnt_nxt = cnt_r;
        endcase
      end
      // read-out, one bit per falling read strobe
      if (rd_fall && state_r == D_DATA) begin
        dout_nxt = ram_r[addr_r][rcnt_r];
        doe_b_nxt = 1'b0;
        rcnt_nxt = rcnt_r + 2'h1;
        if (rd_mode_r && rcnt_r == lmscp_pkg::LAST_RBIT) begin
          addr_nxt = addr_r + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= D_MODE;
      cnt_r <= 4'h0;
      rcnt_r <= 2'h0;
      shift_r <= 9'h000;
      addr_r <= 7'h00;
      rd_mode_r <= 1'b0;
      dout_r <= 1'b1;
      doe_b_r <= 1'b1;
      cfg_r <= lmscp_pkg::CFG_RESET;
      rdat_r <= 4'h0;
      for (int i = 0; i < lmscp_pkg::RAM_DEPTH; i++) begin
        ram_r[i] <= 4'h0;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rcnt_r <= rcnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      rd_mode_r <= rd_mode_nxt;
      dout_r <= dout_nxt;
      doe_b_r <= doe_b_nxt;
      cfg_r <= cfg_nxt;
      rdat_r <= rdat_nxt;
      ram_r <= ram_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.dev_data = dout_r;
  assign link.dev_data_oe_b = doe_b_r;
  assign ram_rd_data_out = rdat_r;
  assign osc_en_out = cfg_r.osc_en;
  assign display_en_out = cfg_r.disp_en;
  assign blink_en_out = cfg_r.blink_en;
  assign leader_mode_out = cfg_r.leader;
  assign pwm_duty_out = cfg_r.pwm;

endmodule

//--- src/lmscp_host.sv
/*
 * host end of the led matrix serial command port: turns requests into
 * chip select, strobe and data sequences, collects read nibbles.
 * assumes one request at a time; strobe phases last one sys_clk each.
 */
`timescale 1ns/1ns
module lmscp_host (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  lmscp_link_if.host link,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire lmscp_pkg::lmscp_kind_t req_kind_in,
  input wire logic [6:0] req_addr_in,
  input wire logic [3:0] req_wdata_in,
  input wire logic [8:0] req_cmd_in,
  input wire logic req_hold_in,
  output logic rsp_valid_out,
  output logic [3:0] rsp_rdata_out
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_GAP = 2'b01,
    H_SEND = 2'b10,
    H_READ = 2'b11
  } lmscp_hst_t;

  // nibbles travel lsb first, so reverse before msb-first shifting
  function automatic logic [3:0] rev4(input logic [3:0] d);
    return {d[0], d[1], d[2], d[3]};
  endfunction

  lmscp_hst_t st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [4:0] left_r, left_nxt;
  logic [2:0] gap_r, gap_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [3:0] rx_r, rx_nxt;
  logic [3:0] wdata_r, wdata_nxt;
  lmscp_pkg::lmscp_kind_t kind_r, kind_nxt;
  logic need_rd_r, need_rd_nxt;
  logic hold_r, hold_nxt;
  logic open_r, open_nxt;
  logic cs_b_r, cs_b_nxt, wr_b_r, wr_b_nxt, rd_b_r, rd_b_nxt;
  logic dout_r, dout_nxt, doe_b_r, doe_b_nxt;
  logic rsp_r, rsp_nxt;
  logic [3:0] rdata_r, rdata_nxt;
  logic sync1_r, sync2_r;
  logic cont, finish;

  // ****************************************
  // data line synchroniser
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= link.data_line;
      sync2_r <= sync1_r;
    end
  end

  assign req_ready_out = (st_r == H_IDLE);
  // same kind with select still low continues without a header
  assign cont = open_r && (req_kind_in == kind_r);

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    left_nxt = left_r;
    gap_nxt = gap_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    wdata_nxt = wdata_r;
    kind_nxt = kind_r;
    need_rd_nxt = need_rd_r;
    hold_nxt = hold_r;
    open_nxt = open_r;
    cs_b_nxt = cs_b_r;
    wr_b_nxt = wr_b_r;
    rd_b_nxt = rd_b_r;
    dout_nxt = dout_r;
    doe_b_nxt = doe_b_r;
    rsp_nxt = 1'b0;
    rdata_nxt = rdata_r;
    finish = 1'b0;
    unique case (st_r)
      H_IDLE: begin
        if (req_valid_in) begin
          kind_nxt = req_kind_in;
          wdata_nxt = req_wdata_in;
          hold_nxt = req_hold_in;
          need_rd_nxt = (req_kind_in == lmscp_pkg::K_READ || req_kind_in == lmscp_pkg::K_RMW);
          ph_nxt = lmscp_pkg::PH_A;
          unique case (req_kind_in)
            lmscp_pkg::K_CMD: begin
              tx_nxt = cont ? {req_cmd_in, 7'h00} : {lmscp_pkg::MODE_CMD, req_cmd_in, 4'h0};
              left_nxt = cont ? lmscp_pkg::LEN_CMD : lmscp_pkg::LEN_HDR_CMD;
            end
            lmscp_pkg::K_WRITE: begin
              tx_nxt = cont ? {rev4(req_wdata_in), 12'h000}
                            : {lmscp_pkg::MODE_WRITE, req_addr_in, rev4(req_wdata_in), 2'h0};
              left_nxt = cont ? lmscp_pkg::LEN_NIB : lmscp_pkg::LEN_HDR_WR;
            end
            lmscp_pkg::K_READ: begin
              tx_nxt = {lmscp_pkg::MODE_READ, req_addr_in, 6'h00};
              left_nxt = cont ? 5'h00 : lmscp_pkg::LEN_HDR_RD;
            end
            lmscp_pkg::K_RMW: begin
              tx_nxt = {lmscp_pkg::MODE_WRITE, req_addr_in, 6'h00};
              left_nxt = cont ? 5'h00 : lmscp_pkg::LEN_HDR_RD;
            end
          endcase
          if (!cont) begin
            st_nxt = H_GAP;
            cs_b_nxt = 1'b1;
            gap_nxt = 3'h0;
          end else if (req_kind_in == lmscp_pkg::K_CMD || req_kind_in == lmscp_pkg::K_WRITE) begin
            st_nxt = H_SEND;
          end else begin
            st_nxt = H_READ;
            left_nxt = lmscp_pkg::LEN_NIB;
          end
        end
      end
      H_GAP: begin
        // high pulse on select before every new mode id
        gap_nxt = gap_r + 3'h1;
        if (gap_r == lmscp_pkg::GAP_CYC - 3'h1) begin
          cs_b_nxt = 1'b0;
          st_nxt = (left_r == 5'h00) ? H_READ : H_SEND;
          if (left_r == 5'h00) begin
            left_nxt = lmscp_pkg::LEN_NIB;
          end
        end
      end
      H_SEND: begin
        ph_nxt = ph_r + 2'h1;
        unique case (ph_r)
          lmscp_pkg::PH_A: wr_b_nxt = 1'b0;
          lmscp_pkg::PH_B: begin
            doe_b_nxt = 1'b0;
            dout_nxt = tx_r[lmscp_pkg::TX_W-1];
          end
          lmscp_pkg::PH_C: wr_b_nxt = 1'b1;
          lmscp_pkg::PH_D: begin
            tx_nxt = {tx_r[lmscp_pkg::TX_W-2:0], 1'b0};
            left_nxt = left_r - 5'h01;
            if (left_r == 5'h01) begin
              doe_b_nxt = 1'b1;
              if (need_rd_r) begin
                st_nxt = H_READ;
                left_nxt = lmscp_pkg::LEN_NIB;
              end else begin
                finish = 1'b1;
              end
            end
          end
        endcase
      end
      H_READ: begin
        ph_nxt = ph_r + 2'h1;
        need_rd_nxt = 1'b0;
        unique case (ph_r)
          lmscp_pkg::PH_A: rd_b_nxt = 1'b0;
          lmscp_pkg::PH_B: rd_b_nxt = 1'b0;
          lmscp_pkg::PH_C: rd_b_nxt = 1'b1;
          lmscp_pkg::PH_D: begin
            rx_nxt = {sync2_r, rx_r[lmscp_pkg::NIB_W-1:1]};
            left_nxt = left_r - 5'h01;
            if (left_r == 5'h01) begin
              rdata_nxt = {sync2_r, rx_r[lmscp_pkg::NIB_W-1:1]};
              if (kind_r == lmscp_pkg::K_RMW) begin
                st_nxt = H_SEND;
                tx_nxt = {rev4(wdata_r), 12'h000};
                left_nxt = lmscp_pkg::LEN_NIB;
              end else begin
                finish = 1'b1;
              end
            end
          end
        endcase
      end
    endcase
    if (finish) begin
      st_nxt = H_IDLE;
      rsp_nxt = 1'b1;
      open_nxt = hold_r;
      cs_b_nxt = !hold_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= H_IDLE;
      ph_r <= lmscp_pkg::PH_A;
      left_r <= 5'h00;
      gap_r <= 3'h0;
      tx_r <= 16'h0000;
      rx_r <= 4'h0;
      wdata_r <= 4'h0;
      kind_r <= lmscp_pkg::K_READ;
      need_rd_r <= 1'b0;
      hold_r <= 1'b0;
      open_r <= 1'b0;
      cs_b_r <= 1'b1;
      wr_b_r <= 1'b1;
      rd_b_r <= 1'b1;
      dout_r <= 1'b1;
      doe_b_r <= 1'b1;
      rsp_r <= 1'b0;
      rdata_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      left_r <= left_nxt;
      gap_r <= gap_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      wdata_r <= wdata_nxt;
      kind_r <= kind_nxt;
      need_rd_r <= need_rd_nxt;
      hold_r <= hold_nxt;
      open_r <= open_nxt;
      cs_b_r <= cs_b_nxt;
      wr_b_r <= wr_b_nxt;
      rd_b_r <= rd_b_nxt;
      dout_r <= dout_nxt;
      doe_b_r <= doe_b_nxt;
      rsp_r <= rsp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.cs_b = cs_b_r; // one select per device
  assign link.wr_b = wr_b_r;
  assign link.rd_b = rd_b_r;
  assign link.host_data = dout_r;
  assign link.host_data_oe_b = doe_b_r;
  assign rsp_valid_out = rsp_r;
  assign rsp_rdata_out = rdata_r;

endmodule

//--- src/lmscp_link_if.sv
/*
 * link between host and device: chip select, write and read strobes and
 * the shared data line, resolved here from the two output enables.
 * assumes a pull-up on the data line when nobody drives it.
 */
`timescale 1ns/1ns
interface lmscp_link_if;
  logic cs_b;
  logic wr_b;
  logic rd_b;
  logic host_data;
  logic host_data_oe_b;
  logic dev_data;
  logic dev_data_oe_b;
  logic data_line;

  // ****************************************
  // wire level of the data line
  // ****************************************
  // driver with low enable wins, pull-up otherwise
  assign data_line = !host_data_oe_b ? host_data : (!dev_data_oe_b ? dev_data : 1'b1);

  modport host (output cs_b, output wr_b, output rd_b, output host_data,
                output host_data_oe_b, input data_line);
  modport dev (input cs_b, input wr_b, input rd_b, input data_line,
               output dev_data, output dev_data_oe_b);
endinterface

//--- src/lmscp_pkg.sv
/*
 * shared constants and types for the led matrix serial command port:
 * mode ids, field positions, bit counts, command codes, reset defaults
 * and host strobe phases.
 * assumes both ends and the link interface are compiled after it.
 */
package lmscp_pkg;

  // ****************************************
  // transfer formats
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int CMD_W = 9;
  localparam int RAM_DEPTH = 128;
  localparam int TX_W = 16;
  localparam logic [2:0] MODE_READ = 3'h6;
  localparam logic [2:0] MODE_WRITE = 3'h5;
  localparam logic [2:0] MODE_CMD = 3'h4;
  // last bit index of each field, counted from zero
  localparam logic [3:0] LAST_MODE = 4'h2;
  localparam logic [3:0] LAST_ADDR = 4'h6;
  localparam logic [3:0] LAST_NIB = 4'h3;
  localparam logic [3:0] LAST_CMD = 4'h8;
  localparam logic [1:0] LAST_RBIT = 2'h3;

  // ****************************************
  // synchronised pin vector of the device
  // ****************************************
  localparam int PIN_CS = 3;
  localparam int PIN_WR = 2;
  localparam int PIN_RD = 1;
  localparam int PIN_DAT = 0;
  localparam logic [3:0] PIN_IDLE = 4'hf;

  // ****************************************
  // command word fields and codes
  // ****************************************
  localparam int C_HI = 8;
  localparam int C_GRP_LO = 5;
  localparam int C_OP_HI = 4;
  localparam int C_OP_LO = 1;
  localparam int C_SLV_LO = 4;
  localparam int C_LDR_LO = 3;
  localparam int C_PWM_LO = 6;
  localparam logic [3:0] GRP_SYS = 4'h0;
  localparam logic [3:0] OP_OSC_OFF = 4'h0;
  localparam logic [3:0] OP_OSC_ON = 4'h1;
  localparam logic [3:0] OP_DISP_OFF = 4'h2;
  localparam logic [3:0] OP_DISP_ON = 4'h3;
  localparam logic [3:0] OP_BLINK_OFF = 4'h8;
  localparam logic [3:0] OP_BLINK_ON = 4'h9;
  localparam logic [4:0] PFX_SLAVE = 5'h02;
  localparam logic [5:0] PFX_LEADER = 6'h06;
  localparam logic [2:0] PFX_PWM = 3'h5;

  typedef struct packed {
    logic osc_en;
    logic disp_en;
    logic blink_en;
    logic leader;
    logic [3:0] pwm;
  } lmscp_cfg_t;

  localparam lmscp_cfg_t CFG_RESET = '{osc_en: 1'b0, disp_en: 1'b0, blink_en: 1'b0,
                                        leader: 1'b1, pwm: 4'hf};

  // ****************************************
  // host side
  // ****************************************
  typedef enum logic [1:0] {
    K_READ = 2'b00,
    K_WRITE = 2'b01,
    K_RMW = 2'b10,
    K_CMD = 2'b11
  } lmscp_kind_t;

  localparam logic [1:0] PH_A = 2'h0;
  localparam logic [1:0] PH_B = 2'h1;
  localparam logic [1:0] PH_C = 2'h2;
  localparam logic [1:0] PH_D = 2'h3;
  localparam logic [2:0] GAP_CYC = 3'h2;
  localparam logic [4:0] LEN_HDR_CMD = 5'h0c;
  localparam logic [4:0] LEN_HDR_WR = 5'h0e;
  localparam logic [4:0] LEN_HDR_RD = 5'h0a;
  localparam logic [4:0] LEN_CMD = 5'h09;
  localparam logic [4:0] LEN_NIB = 5'h04;

endpackage

//--- testbench/led_matrix_serial_command_port_test.sv
/* self-checking bench: host and device joined by the link interface.
   assumes the src files are compiled first. */
`timescale 1ns/1ns
module led_matrix_serial_command_port_test;
  logic sys_clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, req_hold, rsp_valid;
  lmscp_pkg::lmscp_kind_t req_kind = lmscp_pkg::K_CMD;
  logic [6:0] req_addr, base;
  logic [6:0] ram_addr = 7'h00;
  logic [3:0] req_wdata, rsp_rdata, ram_data, wd;
  logic [8:0] req_cmd;
  logic [4:0] note;
  logic [4:0] notes [$];
  logic [3:0] mem [128] = '{default: 4'h0};
  lmscp_pkg::lmscp_cfg_t cfg;
  logic [8:0] cmds [12] = '{9'h003, 9'h006, 9'h013, 9'h02f, 9'h1c1, 9'h03b,
                            9'h033, 9'h16a, 9'h010, 9'h005, 9'h007, 9'h001};
  logic [7:0] cfgs [12] = '{8'h9f, 8'hdf, 8'hff, 8'hef, 8'hef, 8'hef,
                            8'hff, 8'hf5, 8'hd5, 8'h95, 8'hd5, 8'h15};
  int mismatches = 0;
  int checks = 0;
  // clocks
  always #50 sys_clk_in = ~sys_clk_in;
  always #3 link_clk = ~link_clk;
  lmscp_link_if i_lmscp_link_if ();
  lmscp_host i_lmscp_host (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b),
    .link(i_lmscp_link_if.host), .req_valid_in(req_valid), .req_ready_out(req_ready),
    .req_kind_in(req_kind), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_cmd_in(req_cmd), .req_hold_in(req_hold), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata));
  lmscp_device i_lmscp_device (.link_clk_in(link_clk), .rst_b_in(rst_b),
    .link(i_lmscp_link_if.dev), .ram_rd_addr_in(ram_addr), .ram_rd_data_out(ram_data),
    .osc_en_out(cfg.osc_en), .display_en_out(cfg.disp_en), .blink_en_out(cfg.blink_en),
    .leader_mode_out(cfg.leader), .pwm_duty_out(cfg.pwm));
  lmscp_assertions i_lmscp_assertions (.sys_clk_in(sys_clk_in), .link_clk_in(link_clk),
    .rst_b_in(rst_b), .cs_b_in(i_lmscp_link_if.cs_b), .wr_b_in(i_lmscp_link_if.wr_b),
    .rd_b_in(i_lmscp_link_if.rd_b), .host_data_in(i_lmscp_link_if.host_data),
    .host_data_oe_b_in(i_lmscp_link_if.host_data_oe_b),
    .dev_data_oe_b_in(i_lmscp_link_if.dev_data_oe_b));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // closing report
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request, note of the expected answer queued first
  task automatic send(input lmscp_pkg::lmscp_kind_t k, input logic [6:0] a,
      input logic [8:0] c, input logic [3:0] d, input logic h, input logic [4:0] n);
    while (req_ready !== 1'b1) @(negedge sys_clk_in);
    notes.push_back(n);
    req_kind = k;
    req_addr = a;
    req_cmd = c;
    req_wdata = d;
    req_hold = h;
    req_valid = 1'b1;
    @(negedge sys_clk_in);
    req_valid = 1'b0;
  endtask
  // wait for the host to finish
  task automatic settle();
    while (req_ready !== 1'b1) @(negedge sys_clk_in);
    repeat (2) @(negedge sys_clk_in);
  endtask
  // answer watcher
  always @(negedge sys_clk_in) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) check(8'h01, 8'h00);
      else begin
        note = notes.pop_front();
        if (note[4]) check({4'h0, rsp_rdata}, {4'h0, note[3:0]});
      end
    end
  end
  // watchdog
  initial begin
    repeat (5000) @(negedge sys_clk_in); // about three times the expected run
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial begin
    {req_hold, req_addr, req_cmd, req_wdata} = 21'h00_0000;
    void'($urandom(50));
    repeat (3) @(negedge sys_clk_in);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check(cfg, 8'h1f);
    foreach (cmds[i]) begin
      send(lmscp_pkg::K_CMD, 7'h00, cmds[i], 4'h0, 1'b1, 5'h00);
      settle();
      check(cfg, cfgs[i]);
    end
    for (int d = 0; d < 16; d++) begin
      send(lmscp_pkg::K_CMD, 7'h00, {3'h5, 1'($urandom), d[3:0], 1'($urandom)}, 4'h0,
           d < 15, 5'h00);
      settle();
      check(cfg, {4'h1, d[3:0]});
    end
    base = 7'($urandom_range(120));
    for (int i = 0; i < 4; i++) begin
      wd = 4'($urandom);
      mem[base + i] = wd;
      send(lmscp_pkg::K_WRITE, base, 9'h000, wd, i < 3, 5'h00);
    end
    settle();
    for (int i = 0; i < 4; i++) begin
      ram_addr = base + 7'(i);
      @(negedge sys_clk_in);
      check({4'h0, ram_data}, {4'h0, mem[base + i]});
    end
    for (int i = 0; i < 4; i++)
      send(lmscp_pkg::K_READ, base, 9'h000, 4'h0, i < 3, {1'b1, mem[base + i]});
    for (int i = 0; i < 2; i++) begin
      wd = 4'($urandom);
      send(lmscp_pkg::K_RMW, base, 9'h000, wd, i == 0, {1'b1, mem[base + i]});
      mem[base + i] = wd;
    end
    send(lmscp_pkg::K_READ, base + 7'h01, 9'h000, 4'h0, 1'b0, {1'b1, mem[base + 1]});
    settle();
    wrap_up();
  end
endmodule

//--- testbench/lmscp_assertions.sv
/* checker on the link pins between host and device.
   assumes it is instantiated beside the link interface. */
`timescale 1ns/1ns
module lmscp_assertions (
  input wire logic sys_clk_in,
  input wire logic link_clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic wr_b_in,
  input wire logic rd_b_in,
  input wire logic host_data_in,
  input wire logic host_data_oe_b_in,
  input wire logic dev_data_oe_b_in
);
  // ****
  // host strobes, system clock
  // ****
  // strobe low two cycles then high
  sequence s_pulse(s);
    !s [*2] ##1 s;
  endsequence
  a_wr_shape: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(wr_b_in) |-> s_pulse(wr_b_in)) else $error("write strobe shape wrong");
  a_rd_shape: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(rd_b_in) |-> s_pulse(rd_b_in)) else $error("read strobe shape wrong");
  a_wr_data_held: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(wr_b_in) && !cs_b_in |-> !host_data_oe_b_in && $stable(host_data_in))
    else $error("host data not held at write rise");
  a_rd_data_ready: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(rd_b_in) && !cs_b_in |-> !dev_data_oe_b_in && host_data_oe_b_in)
    else $error("device not driving at read rise");
  a_no_fight: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !host_data_oe_b_in |-> dev_data_oe_b_in) else $error("both ends drive data");
  a_cs_gap: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(cs_b_in) |=> cs_b_in) else $error("select pulse too short");
  // ****
  // device answers, link clock
  // ****
  a_dev_release: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $fell(wr_b_in) |-> ##[1:8] dev_data_oe_b_in) else $error("device holds data on write");
  a_dev_cs_idle: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $rose(cs_b_in) |-> ##[1:8] dev_data_oe_b_in) else $error("device drives after select");
  a_dev_answer: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $fell(rd_b_in) && !cs_b_in |-> ##[1:10] !dev_data_oe_b_in) else $error("no read answer");
endmodule
